// file: dmd_top.sv
`timescale 1ns/1ns
`default_nettype none
module dmd_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire dmd_pkg::dmd_quant_s quant,
  output logic [7:0] dac_code1,
  output logic [7:0] dac_code2
);
  // Low word of a wide quantity: unsigned
  function automatic logic signed [17:0] zx16(input logic [15:0] w);
    zx16 = signed'({2'b00, w});
  endfunction

  // High word, signed words: sign extended
  function automatic logic signed [17:0] sx16(input logic [15:0] w);
    sx16 = signed'({{2{w[15]}}, w});
  endfunction

  function automatic dmd_pkg::dmd_sel_s select_raw(
    input logic [15:0] dn,
    input dmd_pkg::dmd_quant_s q,
    input logic chan_two
  );
    dmd_pkg::dmd_sel_s s;
    s.meter = 1'b0;
    s.raw = 18'sh0_0000;
    case (dn)
      dmd_pkg::DN_METER:
      begin
        s.meter = 1'b1;
        s.raw = chan_two ? sx16(q.cur_fb) : sx16(q.speed_fb);
      end
      dmd_pkg::DN_CUR_CMD:
      begin
        s.raw = sx16(q.cur_cmd);
      end
      dmd_pkg::DN_CUR_FB:
      begin
        s.raw = sx16(q.cur_fb);
      end
      dmd_pkg::DN_SPEED:
      begin
        s.raw = sx16(q.speed_fb);
      end
      dmd_pkg::DN_DROOP_LO:
      begin
        s.raw = zx16(q.droop[15:0]);
      end
      dmd_pkg::DN_DROOP_HI:
      begin
        s.raw = sx16(q.droop[31:16]);
      end
      dmd_pkg::DN_INCR_LO:
      begin
        s.raw = zx16(q.incr[15:0]);
      end
      dmd_pkg::DN_INCR_HI:
      begin
        s.raw = sx16(q.incr[31:16]);
      end
      dmd_pkg::DN_POSCMD_LO:
      begin
        s.raw = zx16(q.pos_cmd[15:0]);
      end
      dmd_pkg::DN_POSCMD_HI:
      begin
        s.raw = sx16(q.pos_cmd[31:16]);
      end
      dmd_pkg::DN_FBPOS_LO:
      begin
        s.raw = zx16(q.fb_pos[15:0]);
      end
      dmd_pkg::DN_FBPOS_HI:
      begin
        s.raw = sx16(q.fb_pos[31:16]);
      end
      dmd_pkg::DN_CTL_IN1:
      begin
        s.raw = zx16(q.ctl_in[0]);
      end
      dmd_pkg::DN_CTL_IN2:
      begin
        s.raw = zx16(q.ctl_in[1]);
      end
      dmd_pkg::DN_CTL_IN3:
      begin
        s.raw = zx16(q.ctl_in[2]);
      end
      dmd_pkg::DN_CTL_IN4:
      begin
        s.raw = zx16(q.ctl_in[3]);
      end
      dmd_pkg::DN_CTL_OUT1:
      begin
        s.raw = zx16(q.ctl_out[0]);
      end
      dmd_pkg::DN_CTL_OUT2:
      begin
        s.raw = zx16(q.ctl_out[1]);
      end
      dmd_pkg::DN_CTL_OUT3:
      begin
        s.raw = zx16(q.ctl_out[2]);
      end
      dmd_pkg::DN_CTL_OUT4:
      begin
        s.raw = zx16(q.ctl_out[3]);
      end
      default:
      begin
        // Unknown numbers show mid-scale
        s.raw = 18'sh0_0000;
      end
    endcase
    select_raw = s;
  endfunction

  dmd_pkg::dmd_regs_s regs_ff;
  dmd_pkg::dmd_regs_s nxt_regs;
  dmd_pkg::dmd_aphase_s aph_ff;
  dmd_pkg::dmd_aphase_s nxt_aph;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] code1_ff;
  logic [7:0] code2_ff;
  logic [7:0] nxt_code1;
  logic [7:0] nxt_code2;
  dmd_pkg::dmd_sel_s sel1;
  dmd_pkg::dmd_sel_s sel2;
  logic [7:0] scaled_code1;
  logic [7:0] scaled_code2;
  logic take;

  // Bus group: address phase capture, register writes, read data
  always_comb
  begin
    take = hsel && hready && (htrans == dmd_pkg::HTRANS_NONSEQ)
      && (hsize == dmd_pkg::HSIZE_WORD);
    nxt_aph.valid = take;
    nxt_aph.write = hwrite;
    nxt_aph.addr = haddr[7:0];
    nxt_regs = regs_ff;
    if (aph_ff.valid && aph_ff.write)
    begin
      case (aph_ff.addr)
        dmd_pkg::ADDR_SRC1:
        begin
          nxt_regs.src1 = hwdata[15:0];
        end
        dmd_pkg::ADDR_SRC2:
        begin
          nxt_regs.src2 = hwdata[15:0];
        end
        dmd_pkg::ADDR_GAIN1:
        begin
          nxt_regs.gain1 = hwdata[15:0];
        end
        dmd_pkg::ADDR_GAIN2:
        begin
          nxt_regs.gain2 = hwdata[15:0];
        end
        dmd_pkg::ADDR_SPD_FACTOR:
        begin
          nxt_regs.spd_factor = hwdata[15:0];
        end
        default:
        begin
          nxt_regs = regs_ff;
        end
      endcase
    end
    // Read data from next values so a write just before is seen
    nxt_rdata = 32'h0000_0000;
    if (take && !hwrite)
    begin
      case (haddr[7:0])
        dmd_pkg::ADDR_SRC1:
        begin
          nxt_rdata = {16'h0000, nxt_regs.src1};
        end
        dmd_pkg::ADDR_SRC2:
        begin
          nxt_rdata = {16'h0000, nxt_regs.src2};
        end
        dmd_pkg::ADDR_GAIN1:
        begin
          nxt_rdata = {16'h0000, nxt_regs.gain1};
        end
        dmd_pkg::ADDR_GAIN2:
        begin
          nxt_rdata = {16'h0000, nxt_regs.gain2};
        end
        dmd_pkg::ADDR_SPD_FACTOR:
        begin
          nxt_rdata = {16'h0000, nxt_regs.spd_factor};
        end
        dmd_pkg::ADDR_CODES:
        begin
          nxt_rdata = {16'h0000, code2_ff, code1_ff};
        end
        default:
        begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      regs_ff.src1 <= dmd_pkg::REG_RST;
      regs_ff.src2 <= dmd_pkg::REG_RST;
      regs_ff.gain1 <= dmd_pkg::REG_RST;
      regs_ff.gain2 <= dmd_pkg::REG_RST;
      regs_ff.spd_factor <= dmd_pkg::SPD_FACTOR_RST;
      aph_ff <= '0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      regs_ff <= nxt_regs;
      aph_ff <= nxt_aph;
      rdata_ff <= nxt_rdata;
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Output group: selection, scaling, registered codes
  always_comb
  begin
    sel1 = select_raw(regs_ff.src1, quant, 1'b0);
    sel2 = select_raw(regs_ff.src2, quant, 1'b1);
    nxt_code1 = scaled_code1;
    nxt_code2 = scaled_code2;
  end

  dmd_scale u_scale1 (
    .sel(sel1),
    .gain(regs_ff.gain1),
    .meter_factor(regs_ff.spd_factor),
    .code(scaled_code1)
  );

  dmd_scale u_scale2 (
    .sel(sel2),
    .gain(regs_ff.gain2),
    .meter_factor(dmd_pkg::LOAD_FACTOR),
    .code(scaled_code2)
  );

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      code1_ff <= dmd_pkg::CODE_MIN;
      code2_ff <= dmd_pkg::CODE_MIN;
    end
    else
    begin
      code1_ff <= nxt_code1;
      code2_ff <= nxt_code2;
    end
  end

  assign dac_code1 = code1_ff;
  assign dac_code2 = code2_ff;
endmodule // dmd_top
`default_nettype wire

// file: dmd_pkg.sv
`default_nettype none
package dmd_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_SRC1 = 8'h00;
  localparam logic [7:0] ADDR_SRC2 = 8'h04;
  localparam logic [7:0] ADDR_GAIN1 = 8'h08;
  localparam logic [7:0] ADDR_GAIN2 = 8'h0C;
  localparam logic [7:0] ADDR_SPD_FACTOR = 8'h10;
  localparam logic [7:0] ADDR_CODES = 8'h14;
  localparam logic [15:0] REG_RST = 16'h0000;
  // Speed meter factor: code = |speed| * factor / 65536, default for 6000 r/min
  localparam logic [15:0] SPD_FACTOR_RST = 16'h0AE2;
  // Load meter: 120 percent of 4096 gives full code
  localparam logic [15:0] LOAD_FACTOR = 16'h0D49;
  localparam int METER_SHIFT = 16;
  localparam int GAIN_SHIFT = 8;
  localparam logic signed [16:0] GAIN_UNITY = 17'sh0_0100;
  localparam logic [7:0] CODE_MID = 8'h80;
  localparam logic [7:0] CODE_MAX = 8'hFF;
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Data numbers
  localparam logic [15:0] DN_METER = 16'h0000;
  localparam logic [15:0] DN_CUR_CMD = 16'h0002;
  localparam logic [15:0] DN_CUR_FB = 16'h0003;
  localparam logic [15:0] DN_SPEED = 16'h0004;
  localparam logic [15:0] DN_DROOP_LO = 16'h0006;
  localparam logic [15:0] DN_DROOP_HI = 16'h0007;
  localparam logic [15:0] DN_INCR_LO = 16'h0008;
  localparam logic [15:0] DN_INCR_HI = 16'h0009;
  localparam logic [15:0] DN_POSCMD_LO = 16'h000A;
  localparam logic [15:0] DN_POSCMD_HI = 16'h000B;
  localparam logic [15:0] DN_FBPOS_LO = 16'h000C;
  localparam logic [15:0] DN_FBPOS_HI = 16'h000D;
  localparam logic [15:0] DN_CTL_IN1 = 16'h0050;
  localparam logic [15:0] DN_CTL_IN2 = 16'h0051;
  localparam logic [15:0] DN_CTL_IN3 = 16'h0052;
  localparam logic [15:0] DN_CTL_IN4 = 16'h0053;
  localparam logic [15:0] DN_CTL_OUT1 = 16'h0054;
  localparam logic [15:0] DN_CTL_OUT2 = 16'h0055;
  localparam logic [15:0] DN_CTL_OUT3 = 16'h0056;
  localparam logic [15:0] DN_CTL_OUT4 = 16'h0057;

  typedef struct packed {
    logic signed [15:0] cur_cmd;
    logic signed [15:0] cur_fb;
    logic signed [15:0] speed_fb;
    logic [31:0] droop;
    logic [31:0] incr;
    logic [31:0] pos_cmd;
    logic [31:0] fb_pos;
    logic [3:0][15:0] ctl_in;
    logic [3:0][15:0] ctl_out;
  } dmd_quant_s;

  typedef struct packed {
    logic [15:0] src1;
    logic [15:0] src2;
    logic [15:0] gain1;
    logic [15:0] gain2;
    logic [15:0] spd_factor;
  } dmd_regs_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } dmd_aphase_s;

  typedef struct packed {
    logic meter;
    logic signed [17:0] raw;
  } dmd_sel_s;
endpackage
`default_nettype wire

// file: dmd_scale.sv
`timescale 1ns/1ns
`default_nettype none
module dmd_scale (
  input wire dmd_pkg::dmd_sel_s sel,
  input wire logic [15:0] gain,
  input wire logic [15:0] meter_factor,
  output logic [7:0] code
);
  logic signed [16:0] gain_eff;
  logic signed [34:0] product;
  logic signed [34:0] scaled;
  logic signed [35:0] offset_sum;
  logic [34:0] mag;
  logic [15:0] mag16;
  logic [31:0] meter_prod;
  logic [15:0] meter_val;

  always_comb
  begin
    gain_eff = (gain == 16'h0000) ? dmd_pkg::GAIN_UNITY : 17'(signed'(gain));
    product = 35'(sel.raw) * 35'(gain_eff);
    scaled = product >>> dmd_pkg::GAIN_SHIFT;
    offset_sum = 36'(scaled) + 36'(signed'({1'b0, dmd_pkg::CODE_MID}));
    mag = scaled[34] ? 35'(-scaled) : 35'(scaled);
    mag16 = (mag > 35'(16'hFFFF)) ? 16'hFFFF : mag[15:0];
    meter_prod = 32'(mag16) * 32'(meter_factor);
    meter_val = meter_prod[31:dmd_pkg::METER_SHIFT];
    if (sel.meter)
    begin
      code = (meter_val > 16'(dmd_pkg::CODE_MAX)) ? dmd_pkg::CODE_MAX : meter_val[7:0];
    end
    else if (offset_sum < 36'sh0_0000_0000)
    begin
      code = dmd_pkg::CODE_MIN;
    end
    else if (offset_sum > 36'(signed'({1'b0, dmd_pkg::CODE_MAX})))
    begin
      code = dmd_pkg::CODE_MAX;
    end
    else
    begin
      code = offset_sum[7:0];
    end
  end
endmodule // dmd_scale
`default_nettype wire

// file: dmd_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dmd_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire dmd_pkg::dmd_quant_s quant,
  input wire logic [7:0] dac_code1
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic wv_ff;
  logic [7:0] wa_ff;
  logic [15:0] s1_ff;
  logic [15:0] g1_ff;
  logic signed [15:0] spd;
  assign spd = quant.speed_fb;
  // Shadow of channel one settings, seen from bus writes
  always_ff @(posedge clock)
  begin
    wa_ff <= haddr[7:0];
    if (!rstn)
    begin
      wv_ff <= 1'b0;
      s1_ff <= 16'h0000;
      g1_ff <= 16'h0000;
    end
    else
    begin
      wv_ff <= hsel && hready && htrans == 2'h2 && hwrite && hsize == 3'h2;
      if (wv_ff && wa_ff == 8'h00)
        s1_ff <= hwdata[15:0];
      if (wv_ff && wa_ff == 8'h08)
        g1_ff <= hwdata[15:0];
    end
  end
  sequence s_unity;
    s1_ff == 16'h0004 && g1_ff == 16'h0100;
  endsequence
  property p_spd;
    s_unity ##0 (spd == 16'sh0010) |=> dac_code1 == 8'h90;
  endproperty
  property p_zero;
    s1_ff == 16'h0004 && g1_ff == 16'h0000 && spd == 16'sh0010 |=> dac_code1 == 8'h90;
  endproperty
  property p_gain;
    s1_ff == 16'h0004 && g1_ff == 16'h0080 && spd == 16'sh0020 |=> dac_code1 == 8'h90;
  endproperty
  property p_sat_hi;
    s_unity ##0 (spd >= 16'sh00C8) |=> dac_code1 == 8'hFF;
  endproperty
  property p_sat_lo;
    s_unity ##0 (spd <= -16'sh00C8) |=> dac_code1 == 8'h00;
  endproperty
  property p_bits;
    s1_ff == 16'h0057 && g1_ff == 16'h0100 && quant.ctl_out[3] == 16'h0010
      |=> dac_code1 == 8'h90;
  endproperty
  property p_mid;
    s1_ff == 16'h0001 |=> dac_code1 == 8'h80;
  endproperty
  property p_meter;
    s1_ff == 16'h0000 && spd == 16'sh0000 |=> dac_code1 == 8'h00;
  endproperty
  a_spd: assert property (p_spd) else $error("speed code wrong");
  a_zero: assert property (p_zero) else $error("zero gain code wrong");
  a_gain: assert property (p_gain) else $error("gain code wrong");
  a_sat_hi: assert property (p_sat_hi) else $error("no high clamp");
  a_sat_lo: assert property (p_sat_lo) else $error("no low clamp");
  a_bits: assert property (p_bits) else $error("bit word code wrong");
  a_mid: assert property (p_mid) else $error("unused number not mid");
  a_meter: assert property (p_meter) else $error("meter offset seen");
endmodule // dmd_chk
`default_nettype wire

// file: dmd_scope.sv
`timescale 1ns/1ns
`default_nettype none
module dmd_scope (
  input wire logic [7:0] code1,
  input wire logic [7:0] code2,
  output var int mv1,
  output var int mv2
);
  // Ideal 0 to 10 V reading in millivolts
  assign mv1 = int'(code1) * 10000 / 256;
  assign mv2 = int'(code2) * 10000 / 256;
endmodule // dmd_scope
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic clock;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  dmd_pkg::dmd_quant_s quant;
  logic [7:0] dac_code1;
  logic [7:0] dac_code2;
  logic [31:0] rd;
  int mv1;
  int mv2;
  int err_count;
  int total_checks;
  int cyc;
  assign hready = hreadyout;
  dmd_top u_dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .quant(quant), .dac_code1(dac_code1),
    .dac_code2(dac_code2));
  dmd_scope u_scope (.code1(dac_code1), .code2(dac_code2), .mv1(mv1), .mv2(mv2));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic t_regs();
    xfer(1'b0, 8'h00, '0);
    `CHK(rd, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    xfer(1'b0, 8'h10, '0);
    `CHK(rd, 32'h0000_0AE2)
    @(posedge clock);
    `CHK(hrdata, 32'h0000_0000)
    xfer(1'b1, 8'h04, 32'hFFFF_1234);
    xfer(1'b0, 8'h04, '0);
    `CHK(rd, 32'h0000_1234)
    xfer(1'b1, 8'h18, 32'h0000_5555);
    xfer(1'b0, 8'h18, '0);
    `CHK(rd, 32'h0000_0000)
    hsize <= 3'h1;
    xfer(1'b1, 8'h08, 32'h0000_5555);
    hsize <= 3'h2;
    xfer(1'b0, 8'h08, '0);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b1, 8'h10, 32'h0000_1234);
    xfer(1'b0, 8'h10, '0);
    `CHK(rd, 32'h0000_1234)
    xfer(1'b1, 8'h10, {16'h0000, dmd_pkg::SPD_FACTOR_RST});
  endtask
  task automatic t_meter();
    xfer(1'b1, 8'h04, '0);
    repeat (2) @(posedge clock);
    `CHK(dac_code1, 8'h00)
    `CHK(dac_code2, 8'h00)
    quant.speed_fb <= 16'sh0BB8;
    quant.cur_fb <= 16'sh07D0;
    repeat (2) @(posedge clock);
    `CHK(dac_code1, 8'((3000 * dmd_pkg::SPD_FACTOR_RST) >> 16))
    `CHK(dac_code2, 8'((2000 * dmd_pkg::LOAD_FACTOR) >> 16))
    quant.speed_fb <= 16'sh1770;
    quant.cur_fb <= 16'sh1333;
    repeat (2) @(posedge clock);
    `CHK(dac_code1, 8'hFF)
    `CHK(dac_code2, 8'hFF)
    quant.speed_fb <= -16'sh1770;
    repeat (2) @(posedge clock);
    `CHK(dac_code1, 8'hFF)
  endtask
  task automatic t_sel();
    logic [7:0] e;
    quant <= '{cur_cmd: 16'sh0002, cur_fb: 16'sh0003, speed_fb: 16'sh0004,
      droop: 32'h0007_0006, incr: 32'h0009_0008, pos_cmd: 32'h000B_000A,
      fb_pos: 32'h000D_000C, ctl_in: 64'h0053_0052_0051_0050,
      ctl_out: 64'h0057_0056_0055_0054};
    for (int dn = 1; dn < 90; dn++)
    begin
      xfer(1'b1, 8'h00, dn);
      xfer(1'b1, 8'h04, dn);
      repeat (2) @(posedge clock);
      e = ((dn >= 2 && dn <= 13 && dn != 5) || (dn >= 80 && dn <= 87)) ? 8'(128 + dn) : 8'h80;
      `CHK(dac_code1, e)
      `CHK(dac_code2, e)
    end
  endtask
  task automatic t_gain();
    logic [15:0] g[6] = '{16'h0000, 16'h0100, 16'h0080, 16'hFF00, 16'h0100, 16'h0100};
    logic [15:0] s[6] = '{16'h0010, 16'h0010, 16'h0020, 16'h0010, 16'h00C8, 16'hFF38};
    logic [7:0] x[6] = '{8'h90, 8'h90, 8'h90, 8'h70, 8'hFF, 8'h00};
    xfer(1'b1, 8'h00, 32'h0000_0004);
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b1, 8'h08, {16'h0000, g[i]});
      quant.speed_fb <= s[i];
      repeat (2) @(posedge clock);
      `CHK(dac_code1, x[i])
    end
    xfer(1'b1, 8'h00, 32'h0000_0057);
    quant.ctl_out[3] <= 16'h0010;
    repeat (2) @(posedge clock);
    `CHK(mv1, 5625)
    quant.ctl_out[3] <= 16'h0011;
    repeat (2) @(posedge clock);
    `CHK(dac_code1, 8'h91)
  endtask
  task automatic t_chan2();
    xfer(1'b1, 8'h04, 32'h0000_0004);
    xfer(1'b1, 8'h0C, 32'h0000_0010);
    xfer(1'b0, 8'h0C, '0);
    `CHK(rd, 32'h0000_0010)
    // Gain of 16/256 keeps 2000 r/min inside the span
    quant.speed_fb <= 16'sh07D0;
    repeat (2) @(posedge clock);
    `CHK(dac_code2, 8'hFD)
    `CHK(dac_code1, 8'h91)
    xfer(1'b0, 8'h14, '0);
    `CHK(rd, 32'h0000_FD91)
  endtask
  initial
  begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    quant = '0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_regs();
    t_meter();
    t_sel();
    t_gain();
    t_chan2();
    give_verdict();
  end
endmodule // tb_top
bind dmd_top dmd_chk u_chk (.*);
`default_nettype wire
